// ===== adc_cal_and_regmap_lock.sv
// Four-channel offset/gain calibration with register-map lock and checksum.
// Assumes samples arrive on sys_clk from the modulator logic, registers over APB.
//
// Our own choice: the APB register port.
`default_nettype none
`include "adc_cal_consts.svh"

// Notes on behaviour
// [RULE_01] With offset correction on, offset is added to the channel code.
// [RULE_02] Offset is a 24-bit two's complement value in bits 23..0.
// [RULE_03] Offset correction off ignores the offset but keeps it stored.
// [RULE_04] Gain value is a signed 24-bit fraction from -1 to just under 1.
// [RULE_05] Offset-corrected code is multiplied by one plus the gain fraction.
// [RULE_06] One gain step changes the multiplier by two to the minus 23.
// [RULE_07] Gain correction off ignores the gain but keeps it stored.
// [RULE_08] Lock field resets to 0xA5; with it, all registers are writable.
// [RULE_09] Unlocked: no checksum is computed; checksum and its interrupt held clear.
// [RULE_10] Locked: only the lock/checksum register accepts writes.
// [RULE_11] Locked: reads of other registers may return undefined data.
// [RULE_12] Locked: checksum runs continuously; interrupt only if enabled.
// [RULE_13] Host unlocks with 0xA5 before writing any other register.
// [RULE_14] Checksum is CRC-16 over the writable map, read-only in bits 15..0; the code covers only the calibration words and the lock byte.
// [RULE_15] Locked: checksum recomputed and published every 16 clock periods.
// [RULE_16] Lock field equal to the password forces the checksum to zero.
// [RULE_17] CRC-16 polynomial 0x8005, init zero, registers in address order.
// [RULE_18] Corrected codes saturate at the word limits instead of wrapping.
module adc_cal_and_regmap_lock
  import adc_cal_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // Clock, reset, enable
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                clkEn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Converter samples in and corrected samples out
  input  wire sample_t [NUM_CH-1:0] rawSample,
  output sample_t      [NUM_CH-1:0] calSample,
  // Interrupt
  output logic                     irq
);

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  cal_pair_t [NUM_CH-1:0] cal_q;
  logic [7:0]  lock_q;
  logic [15:0] crcOut_q;
  logic [15:0] crcAcc_q;
  logic [4:0]  crcCnt_q;
  logic [2:0]  ctrl_q;
  logic [1:0]  irqStat_q;
  logic [1:0]  irqMask_q;
  logic [15:0] crcPrev_q;
  logic        crcPrevValid_q;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  wire        access   = psel & penable & clkEn;
  wire        wrAcc    = access & pwrite;
  wire [9:0]  idx      = paddr[11:2];
  wire        unlocked = (lock_q == `LOCK_PASSWORD);
  wire        hitLock  = (idx == 10'(`IDX_LOCK_CRC));
  wire        hitCtrl  = (idx == 10'(`IDX_CAL_CTRL));
  wire        hitStat  = (idx == 10'(`IDX_IRQ_STATUS));
  wire        hitMask  = (idx == 10'(`IDX_IRQ_MASK));
  wire [9:0]  calRel   = idx - 10'(`IDX_OFFSET_CH0);
  wire        hitCal   = (idx >= 10'(`IDX_OFFSET_CH0)) && (calRel < 10'(2 * NUM_CH));
  wire        mapped   = hitLock | hitCtrl | hitStat | hitMask | hitCal;
  // Locked writes to anything but the lock register are dropped
  wire        wrOk     = wrAcc & mapped & (unlocked | hitLock); // [RULE_10]
  wire [2:0]  calCh    = calRel[3:1];
  wire        calIsGain = calRel[0];

  // Read data selection; calibration words read back normally while
  // locked, which is one legal choice of the undefined answer
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitLock)
      rdMux = {8'h00, lock_q, crcOut_q}; // [RULE_14]
    else if (hitCtrl)
      rdMux = {29'h0, ctrl_q};
    else if (hitStat)
      rdMux = {30'h0, irqStat_q};
    else if (hitMask)
      rdMux = {30'h0, irqMask_q};
    else if (hitCal)
      rdMux = calIsGain ? {8'h00, cal_q[calCh].gain} : {8'h00, cal_q[calCh].offset}; // [RULE_11]
  end

  // -----------------------------------------------------------------
  // APB answer: zero wait states, error on unmapped addresses
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rdMux : prdata;
    end
  end

  // The access phase ends at the edge where registered pready is high;
  // writes commit only on that edge
  wire wrCommit = wrOk & pready;

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lock_q    <= `LOCK_PASSWORD; // [RULE_08]
      ctrl_q    <= 3'h0;
      irqMask_q <= 2'h0;
    end else if (clkEn && wrCommit) begin
      if (hitLock) lock_q <= pwdata[`LOCK_LSB +: 8];
      if (hitCtrl) ctrl_q <= pwdata[2:0];
      if (hitMask) irqMask_q <= pwdata[1:0];
    end
  end

  // Calibration storage; enable bits never touch it
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCalReg
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          cal_q[g] <= '0;
        end else if (clkEn && wrCommit && hitCal && calCh == 3'(g)) begin
          if (calIsGain) cal_q[g].gain <= pwdata[23:0]; // [RULE_07]
          else cal_q[g].offset <= pwdata[23:0]; // [RULE_03]
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Map checksum
  // -----------------------------------------------------------------
  // Message: each channel's offset then gain, in address order, then the
  // lock byte; one bit per clock would be slow, so the message is folded
  // into the accumulator over the first 13 clocks of the 16-clock sweep, one 16-bit slice per clock
  localparam int MSG_W = NUM_CH * 48 + 8;
  localparam int SLICES = (MSG_W + 15) / 16;
  logic [SLICES*16-1:0] msg;
  always_comb begin
    msg = '0;
    // Words sit from the top slice down; the zero pad trails the lock byte
    for (int i = 0; i < NUM_CH; i++) begin
      msg[SLICES*16-1-48*i -: 24] = cal_q[i].offset;
      msg[SLICES*16-25-48*i -: 24] = cal_q[i].gain;
    end
    msg[SLICES*16-1-48*NUM_CH -: 8] = lock_q;
  end

  // CRC-16 advance by sixteen message bits, MSB first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 15; b >= 0; b--)
      r = (r[15] ^ d[b]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    return r;
  endfunction

  wire [4:0]  sliceIdx = crcCnt_q;
  wire [15:0] slice    = (int'(sliceIdx) < SLICES) ?
                         msg[(SLICES-1-int'(sliceIdx))*16 +: 16] : 16'h0000;
  wire        sweepEnd = (crcCnt_q == `CRC_PERIOD - 5'h1);
  wire [15:0] crcNext  = (int'(sliceIdx) < SLICES) ? crcStep(crcAcc_q, slice) : crcAcc_q;

  // Sweep counter runs only while locked; a result is published every 16 clocks
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      crcCnt_q <= 5'h0;
      crcAcc_q <= `CRC_INIT;
      crcOut_q <= 16'h0000;
    end else if (clkEn) begin
      if (unlocked) begin
        crcCnt_q <= 5'h0; // [RULE_09]
        crcAcc_q <= `CRC_INIT;
        crcOut_q <= 16'h0000; // [RULE_16]
      end else begin
        crcCnt_q <= sweepEnd ? 5'h0 : crcCnt_q + 5'h1; // [RULE_15]
        crcAcc_q <= sweepEnd ? `CRC_INIT : crcNext; // [RULE_17]
        if (sweepEnd) crcOut_q <= crcNext; // [RULE_14]
      end
    end
  end

  // -----------------------------------------------------------------
  // Interrupt status
  // -----------------------------------------------------------------
  // Bit 0: a checksum was published; bit 1: it differs from the one before
  wire crcDone   = ~unlocked & sweepEnd & ctrl_q[`CTRL_CRCIE_BIT]; // [RULE_12]
  wire crcChange = crcDone & crcPrevValid_q & (crcNext != crcPrev_q);
  wire [1:0] setEv = {crcChange, crcDone};
  wire [1:0] clrEv = (wrCommit && hitStat) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irqStat_q      <= 2'h0;
      crcPrev_q      <= 16'h0000;
      crcPrevValid_q <= 1'b0;
      irq            <= 1'b0;
    end else if (clkEn) begin
      if (unlocked) begin
        irqStat_q      <= 2'h0; // [RULE_09]
        crcPrevValid_q <= 1'b0;
      end else begin
        irqStat_q <= (irqStat_q & ~clrEv) | setEv; // set wins over clear
        if (sweepEnd) begin
          crcPrev_q      <= crcNext;
          crcPrevValid_q <= 1'b1;
        end
      end
      irq <= |(((irqStat_q & ~clrEv) | setEv) & irqMask_q & {2{~unlocked}});
    end
  end

  // -----------------------------------------------------------------
  // Calibration datapath, one stage per step per channel
  // -----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCal
      logic signed [24:0] offSum;
      logic signed [23:0] offSat;
      logic signed [23:0] offSat_q;
      logic               vld_q;
      logic signed [49:0] prod;
      logic signed [25:0] scaled;
      logic signed [23:0] gainOut;

      // Offset add in 25 bits then clamp
      assign offSum = ctrl_q[`CTRL_OFFEN_BIT] ?
                      ($signed({rawSample[g].code[23], rawSample[g].code}) +
                       $signed({cal_q[g].offset[23], cal_q[g].offset})) : // [RULE_01] [RULE_02]
                      $signed({rawSample[g].code[23], rawSample[g].code});
      assign offSat = (offSum > 25'sh07FFFFF) ? $signed(`SAMPLE_MAX) :
                      (offSum < -25'sh0800000) ? $signed(`SAMPLE_MIN) :
                      offSum[23:0]; // [RULE_18]

      // Multiplier (1 + gain) in Q2.23 is the gain plus 2^23
      wire signed [25:0] mult = $signed({{2{cal_q[g].gain[23]}}, cal_q[g].gain}) +
                                26'sh0800000; // [RULE_04] [RULE_05] [RULE_06]
      assign prod   = 50'(offSat_q * mult);
      assign scaled = prod[48:23];
      assign gainOut = (scaled > 26'sh07FFFFF) ? $signed(`SAMPLE_MAX) :
                       (scaled < -26'sh0800000) ? $signed(`SAMPLE_MIN) :
                       scaled[23:0]; // [RULE_18]

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          offSat_q     <= '0;
          vld_q        <= 1'b0;
          calSample[g] <= '0;
        end else if (clkEn) begin
          offSat_q            <= offSat;
          vld_q               <= rawSample[g].valid;
          calSample[g].valid  <= vld_q;
          calSample[g].code   <= ctrl_q[`CTRL_GAINEN_BIT] ? gainOut : offSat_q; // [RULE_07]
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== adc_cal_consts.svh
// Constants for the converter calibration and register-map lock block.
// Assumes inclusion by the package and the design file by bare name.
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_OFFSET_CH0   8'h0F
`define IDX_GAIN_CH0     8'h10
`define IDX_LOCK_CRC     8'h1F
`define IDX_CAL_CTRL     8'h20
`define IDX_IRQ_STATUS   8'h21
`define IDX_IRQ_MASK     8'h22

// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define LOCK_PASSWORD    8'hA5
`define LOCK_LSB         16
`define CRC_POLY         16'h8005
`define CRC_INIT         16'h0000
`define CRC_PERIOD       5'h10
`define CTRL_OFFEN_BIT   0
`define CTRL_GAINEN_BIT  1
`define CTRL_CRCIE_BIT   2
`define IRQ_CRC_BIT      0
`define IRQ_CHANGE_BIT   1
`define SAMPLE_MAX       24'h7FFFFF
`define SAMPLE_MIN       24'h800000

`endif

// ===== adc_cal_pkg.sv
// Types shared by the calibration block.
// Assumes the constants header sits in the same folder.
`default_nettype none
package adc_cal_pkg;
  `include "adc_cal_consts.svh"

  // One channel sample with its strobe
  typedef struct packed {
    logic        valid;
    logic [23:0] code;
  } sample_t;

  // Per-channel calibration pair
  typedef struct packed {
    logic [23:0] offset;
    logic [23:0] gain;
  } cal_pair_t;
endpackage
`default_nettype wire

// ===== adc_cal_asserts.sv
// Port checker for the calibration and map-lock block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module adc_cal_asserts
  import adc_cal_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire logic                 clkEn,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Samples and interrupt
  input wire sample_t [NUM_CH-1:0] rawSample,
  input wire sample_t [NUM_CH-1:0] calSample,
  input wire logic                 irq
);
  // ----
  // Mirror of lock byte and control bits
  // ----
  logic [7:0] lock_q;
  logic [2:0] ctrl_q;
  logic       locked;
  logic       commit;
  logic       lockRd;
  assign commit = psel && penable && pready && pwrite;
  assign locked = lock_q != 8'hA5;
  assign lockRd = pready && !pwrite && paddr[11:2] == 10'h01F;
  // Control only follows writes made while unlocked, as the map drops others
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lock_q <= 8'hA5;
      ctrl_q <= 3'h0;
    end else if (commit && paddr[11:2] == 10'h01F) begin
      lock_q <= pwdata[23:16];
    end else if (commit && paddr[11:2] == 10'h020 && !locked) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence setupSeen;
    psel && !penable && clkEn;
  endsequence
  ready_pulse_a: assert property (setupSeen |=> pready ##1 !pready)
    else $error("pready is not a one-cycle answer");
  valid_lat_a: assert property (rawSample[0].valid && clkEn |=> ##1 calSample[0].valid)
    else $error("corrected sample late or missing");
  valid_none_a: assert property (!rawSample[1].valid && clkEn |=> ##1 !calSample[1].valid)
    else $error("corrected sample without a raw one");
  bypass_code_a: assert property (rawSample[2].valid && ctrl_q[1:0] == 2'h0
    |=> ##1 calSample[2].code == $past(rawSample[2].code, 2)) else $error("bypass altered code");
  lock_read_a: assert property (lockRd |-> prdata[23:16] == lock_q)
    else $error("lock byte reads wrong");
  crc_zero_a: assert property (lockRd && !locked |-> prdata[15:0] == 16'h0000)
    else $error("checksum not zero while unlocked");
  irq_clear_a: assert property (!locked [*3] |-> !irq)
    else $error("interrupt while unlocked");
  irq_gate_a: assert property (irq |-> ctrl_q[2] && (locked || $past(locked, 2)))
    else $error("interrupt without enable or lock");
endmodule

bind adc_cal_and_regmap_lock adc_cal_asserts #(.NUM_CH(NUM_CH)) u_adc_cal_asserts (
  .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rawSample(rawSample), .calSample(calSample), .irq(irq));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench: APB register traffic, sample math and map lock.
// Assumes the package and the design are compiled first.
`default_nettype none
module testbench import adc_cal_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic          pready, pslverr, irq;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, rd, err;
  logic [23:0]   cal [8];
  sample_t [3:0] rawSample = '0, calSample;
  int            numErrors = 0, checkCount = 0, seed = 57, ctrl = 0, k;

  // Clock source; clkEn tied high, freezing is not exercised
  always #12.5 sys_clk = ~sys_clk;
  adc_cal_and_regmap_lock #(.NUM_CH(4)) u_adc_cal_and_regmap_lock (
    .sys_clk(sys_clk), .resetn(resetn), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rawSample(rawSample), .calSample(calSample), .irq(irq));

  // ----
  // Shared tasks and reference model
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (numErrors == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Read data is taken before the edge's updates land, i.e. as sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Sample pready as it stands at each rising edge of the access phase
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = 32'(pslverr);
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic longint sat(longint v);
    return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
  endfunction
  function automatic logic [23:0] model(int ch, logic [23:0] raw);
    longint v;
    v = longint'($signed(raw));
    if (ctrl[0]) v = sat(v + $signed(cal[2*ch]));
    if (ctrl[1]) v = sat((v * ($signed(cal[2*ch+1]) + 8388608)) >>> 23);
    return v[23:0];
  endfunction
  // Message: eight calibration words in address order, lock byte, zero pad
  function automatic logic [15:0] crc(logic [7:0] lk);
    logic [207:0] m;
    logic [15:0]  c;
    m = '0;
    for (int i = 0; i < 8; i++) m[207-24*i -: 24] = cal[i];
    m[15:8] = lk;
    c = 16'h0000;
    for (int i = 207; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction
  // num beats on all channels, extremes mixed in to reach saturation
  task automatic samples(input int num);
    logic [23:0] e [4];
    logic [23:0] r;
    int          n;
    repeat (num) begin
      @(posedge sys_clk);
      for (int c = 0; c < 4; c++) begin
        r = (num % 3 == 0) ? 24'h7FFFFF : (num % 3 == 1) ? 24'h800000 : 24'($random(seed));
        e[c] = model(c, r);
        rawSample[c] <= {1'b1, r};
      end
      num--;
      @(posedge sys_clk);
      rawSample <= '0;
      for (n = 0; n < 5 && calSample[0].valid !== 1'b1; n++) @(posedge sys_clk);
      for (int c = 0; c < 4; c++) chk({8'h00, calSample[c].code}, {8'h00, e[c]});
    end
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(12'h07C, 32'h00A50000);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(err, 32'h1);
    for (k = 0; k < 8; k++) begin
      cal[k] = (k == 1) ? 24'h800000 : (k == 3) ? 24'h7FFFFF : 24'($random(seed));
      apb(1'b1, 12'h03C + 12'(4 * k), {8'hFF, cal[k]});
      rdchk(12'h03C + 12'(4 * k), {8'h00, cal[k]});
    end
    for (ctrl = 0; ctrl < 4; ctrl++) begin
      apb(1'b1, 12'h080, 32'(ctrl));
      samples(9);
    end
    apb(1'b1, 12'h080, 32'h4);
    apb(1'b1, 12'h088, 32'h0);
    apb(1'b1, 12'h07C, 32'h003C0000);
    apb(1'b1, 12'h03C, 32'h0);
    repeat (40) @(posedge sys_clk);
    rdchk(12'h03C, {8'h00, cal[0]});
    rdchk(12'h07C, {16'h003C, crc(8'h3C)});
    chk(32'(irq), 32'h0);
    apb(1'b1, 12'h07C, 32'h00A50000);
    apb(1'b1, 12'h088, 32'h1);
    apb(1'b1, 12'h07C, 32'h003C0000);
    repeat (40) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    samples(4);
    apb(1'b1, 12'h07C, 32'h00A50000);
    apb(1'b1, 12'h084, 32'h3);
    chk(32'(irq), 32'h0);
    rdchk(12'h07C, 32'h00A50000);
    finish_test();
  end
endmodule
`default_nettype wire
